// ===== hdl/tpg_pkg.sv
/*
  Package for the timer/pulse generator: register offsets, reset values,
  control field layout and the counts of the prescaler and PWM periods.
  Assumes a 32-bit APB slave with byte addresses in a 12-bit window.
*/
package tpg_pkg;

  // Register byte offsets
  localparam logic [11:0] TPG_OFF_CTRL = 12'h000;
  localparam logic [11:0] TPG_OFF_MODULO_HIGH = 12'h004;
  localparam logic [11:0] TPG_OFF_MODULO_LOW = 12'h008;
  localparam logic [11:0] TPG_OFF_STAT = 12'h00c;

  // Values after reset
  localparam logic [7:0]  TPG_CTRL_RST = 8'h00;
  localparam logic [7:0]  TPG_MOD_RST  = 8'h00;

  // Writable control bits: 7, 5, 4, 3, 1, 0
  localparam logic [7:0]  TPG_CTRL_WMASK = 8'hbb;

  // Position of the low modulo field that feeds prescaler and latch, and of the request flag in the status register
  localparam int          TPG_MODULO_LOW_LSB   = 2;
  localparam int          TPG_STAT_IRQ   = 0;

  // PWM periods in fx cycles as powers of two, then latch and prescaler widths
  localparam int          TPG_BASIC_BITS = 10;
  localparam int          TPG_SEC_BITS   = 15;
  localparam int          TPG_LATCH_W    = 14;
  localparam int          TPG_PRE_W      = 8;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic drive;
    logic rsv6;
    logic sel;
    logic level;
    logic reload;
    logic rsv2;
    logic enable;
    logic mode;
  } tpg_ctrl_s;

  typedef enum logic [1:0] {
    TPG_ST_IDLE  = 2'b00,
    TPG_ST_TIMER = 2'b01,
    TPG_ST_PWM   = 2'b11
  } tpg_state_e;

  // Bit-reversed slot index spreads the extra cycles evenly
  function automatic logic [4:0] tpg_rev5(input logic [4:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 5; i++)
      r[i] = v[4 - i];
    return r;
  endfunction : tpg_rev5

endpackage : tpg_pkg

// ===== hdl/tpg_pwm.sv
/*
  PWM core of the timer/pulse generator: reloadable 14-bit latch, working
  copy taken at each basic period, active-low output and secondary event.
  Assumes the parent clears run whenever PWM mode is not active.
*/
`timescale 1ns/10ps
`default_nettype none

module tpg_pwm
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Control
  input  wire logic                   run,
  input  wire logic                   reload_en,
  input  wire logic [7:0]             modulo_high,
  input  wire logic [5:0]             modulo_low_hi,
  // Waveform and event
  output logic                        pwm_n,
  output logic                        period_evt
);

  logic [TPG_SEC_BITS-1:0]   cnt_r;
  logic [TPG_SEC_BITS-1:0]   cnt_nxt;
  logic [TPG_LATCH_W-1:0]    latch_r;
  logic [TPG_LATCH_W-1:0]    latch_nxt;
  logic [TPG_LATCH_W-1:0]    work_r;
  logic [TPG_LATCH_W-1:0]    work_nxt;
  logic                      pwm_r;
  logic                      pwm_nxt;
  logic [TPG_BASIC_BITS-1:0] phase;
  logic [4:0]                slot;
  logic [10:0]               width;
  logic                      extra;

  assign phase = cnt_r[TPG_BASIC_BITS-1:0];
  assign slot  = cnt_r[TPG_SEC_BITS-1:TPG_BASIC_BITS];

  always_comb
  begin
    // Both modulo registers land in one transfer
    latch_nxt = reload_en ? {modulo_high, modulo_low_hi} : latch_r;
    // Changes inside a basic period are not seen before its end
    work_nxt  = (phase == '0) ? latch_r : work_r;
    // Base width plus one fx cycle in 2*frac of 32 periods
    extra     = (tpg_rev5(slot) < {work_nxt[3:0], 1'b0});
    width     = {1'b0, work_nxt[13:4]} + {10'h000, extra};
    cnt_nxt   = run ? cnt_r + 15'h0001 : '0;
    pwm_nxt   = !(run && ({1'b0, phase} < width));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r   <= '0;
      latch_r <= '0;
      work_r  <= '0;
      pwm_r   <= 1'b1;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      latch_r <= latch_nxt;
      work_r  <= work_nxt;
      pwm_r   <= pwm_nxt;
    end
  end

  assign pwm_n      = pwm_r;
  assign period_evt = run && (cnt_r == '1);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_latch_hold: assert property (!reload_en |=> latch_r == $past(latch_r))
    else $error("latch moved while reload disabled");
  a_work_stable: assert property (phase != '0 |=> work_r == $past(work_r))
    else $error("working value changed inside basic period");
  a_evt_spacing: assert property (period_evt |=> !period_evt [*8])
    else $error("secondary events too close");
  a_idle_high: assert property (!run |=> pwm_n)
    else $error("pwm low while stopped");

endmodule : tpg_pwm

`default_nettype wire

// ===== hdl/tpg_top.sv
/*
  Timer/pulse generator with APB register access: interval timer with
  one-hot prescaler and square wave, 14-bit PWM, static pin output.
  Assumes an APB master on pclk; pin wire resolved outside from oe.
*/
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module tpg_top
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pulse output pin
  output logic             pulse_output_pin_o,
  output logic             pulse_output_pin_oe,
  // Request flag
  output logic             pulse_gen_irq_flag,
  output logic             pulse_gen_irq_set
);

  function automatic logic tpg_addr_ok(input logic [11:0] a);
    return (a == TPG_OFF_CTRL) || (a == TPG_OFF_MODULO_HIGH) ||
           (a == TPG_OFF_MODULO_LOW) || (a == TPG_OFF_STAT);
  endfunction : tpg_addr_ok

  // Prescaler tick for a one-hot code; other codes never tick
  function automatic logic tpg_pre_tick(input logic [4:0] code,
                                        input logic [7:0] pre);
    logic t;
    t = 1'b0;
    case (code)
      5'h01:   t = (pre[7:0] == 8'hff);
      5'h02:   t = (pre[6:0] == 7'h7f);
      5'h04:   t = (pre[5:0] == 6'h3f);
      5'h08:   t = (pre[4:0] == 5'h1f);
      5'h10:   t = (pre[3:0] == 4'hf);
      default: t = 1'b0;
    endcase
    return t;
  endfunction : tpg_pre_tick

  // Register file state
  tpg_ctrl_s   ctrl_r;
  tpg_ctrl_s   ctrl_nxt;
  logic [7:0]  modulo_high_r;
  logic [7:0]  modulo_high_nxt;
  logic [7:0]  modulo_low_r;
  logic [7:0]  modulo_low_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        irq_set_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // Generator state
  tpg_state_e       state_r;
  tpg_state_e       state_nxt;
  logic [TPG_PRE_W-1:0] pre_r;
  logic [TPG_PRE_W-1:0] pre_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic        tff_r;
  logic        tff_nxt;
  logic        pin_r;
  logic        pin_nxt;

  logic        acc_wr;
  logic        stat_clr;
  logic        tick;
  logic        timer_evt;
  logic        pwm_evt;
  logic        pwm_n;
  logic        wave;

  assign acc_wr   = psel && penable && pwrite && tpg_addr_ok(paddr);
  assign stat_clr = acc_wr && (paddr == TPG_OFF_STAT) && pwdata[TPG_STAT_IRQ];

  // Zero-wait slave; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !tpg_addr_ok(paddr);
  assign prdata  = prdata_r;

  // Register writes and read capture
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    modulo_high_nxt   = modulo_high_r;
    modulo_low_nxt   = modulo_low_r;
    prdata_nxt = prdata_r;
    if (acc_wr && paddr == TPG_OFF_CTRL)
      ctrl_nxt = tpg_ctrl_s'(pwdata[7:0] & TPG_CTRL_WMASK);
    if (acc_wr && paddr == TPG_OFF_MODULO_HIGH)
      modulo_high_nxt = pwdata[7:0];
    if (acc_wr && paddr == TPG_OFF_MODULO_LOW)
      modulo_low_nxt = pwdata[7:0];
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        TPG_OFF_CTRL: prdata_nxt = {24'h000000, ctrl_r};
        TPG_OFF_MODULO_HIGH: prdata_nxt = {24'h000000, modulo_high_r};
        // Bits 1..0 are not defined to software; they read as zero
        TPG_OFF_MODULO_LOW: prdata_nxt = {24'h000000, modulo_low_r[7:2], 2'b00};
        TPG_OFF_STAT: prdata_nxt = {31'h00000000, irq_r};
        default:      prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= tpg_ctrl_s'(TPG_CTRL_RST);
      modulo_high_r   <= TPG_MOD_RST;
      modulo_low_r   <= TPG_MOD_RST;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      modulo_high_r   <= modulo_high_nxt;
      modulo_low_r   <= modulo_low_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Run state, interval timer and pin
  always_comb
  begin
    state_nxt = TPG_ST_IDLE;
    case (state_r)
      TPG_ST_IDLE, TPG_ST_TIMER, TPG_ST_PWM:
      begin
        if (!ctrl_r.enable)
          state_nxt = TPG_ST_IDLE;
        else if (ctrl_r.mode)
          state_nxt = TPG_ST_TIMER;
        else
          state_nxt = TPG_ST_PWM;
      end
      default: state_nxt = TPG_ST_IDLE;
    endcase

    // Prescaler and count stay cleared outside timer mode, so each
    // entry into it restarts the interval from zero
    tick      = (state_r == TPG_ST_TIMER) &&
                tpg_pre_tick(modulo_low_r[TPG_MODULO_LOW_LSB +: 5], pre_r);
    timer_evt = tick && (cnt_r == modulo_high_r);
    pre_nxt   = (state_r == TPG_ST_TIMER) ? pre_r + 8'h01 : '0;
    cnt_nxt   = cnt_r;
    tff_nxt   = tff_r;
    if (state_r != TPG_ST_TIMER)
      cnt_nxt = 8'h00;
    else if (timer_evt)
    begin
      // Wrap after N+1 ticks: period divisor*(N+1)
      cnt_nxt = 8'h00;
      tff_nxt = !tff_r;
    end
    else if (tick)
      cnt_nxt = cnt_r + 8'h01;

    wave    = (state_r == TPG_ST_TIMER) ? tff_r : pwm_n;
    pin_nxt = ctrl_r.sel ? wave : ctrl_r.level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= TPG_ST_IDLE;
      pre_r   <= '0;
      cnt_r   <= 8'h00;
      tff_r   <= 1'b0;
      pin_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pre_r   <= pre_nxt;
      cnt_r   <= cnt_nxt;
      tff_r   <= tff_nxt;
      pin_r   <= pin_nxt;
    end
  end

  // Request flag: a new event wins over a clear in the same cycle
  always_comb
  begin
    irq_nxt = timer_evt || pwm_evt || (irq_r && !stat_clr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r     <= 1'b0;
      irq_set_r <= 1'b0;
    end
    else
    begin
      irq_r     <= irq_nxt;
      irq_set_r <= timer_evt || pwm_evt;
    end
  end

  tpg_pwm u_pwm (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (state_r == TPG_ST_PWM),
    .reload_en  (ctrl_r.reload),
    .modulo_high       (modulo_high_r),
    .modulo_low_hi    (modulo_low_r[7:2]),
    .pwm_n      (pwm_n),
    .period_evt (pwm_evt)
  );

  assign pulse_output_pin_o  = pin_r;
  assign pulse_output_pin_oe = ctrl_r.drive;
  assign pulse_gen_irq_flag  = irq_r;
  assign pulse_gen_irq_set   = irq_set_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wrap_hit;
    tick && cnt_r == modulo_high_r;
  endsequence

  sequence s_wrap_done;
    cnt_r == 8'h00 && irq_r;
  endsequence

  a_static_level: assert property (!ctrl_r.sel |=> pin_r == $past(ctrl_r.level))
    else $error("static pin does not follow level bit");
  a_pulse_source: assert property (ctrl_r.sel && state_r == TPG_ST_PWM |=> pin_r == $past(pwm_n))
    else $error("pin does not follow pwm waveform");
  a_drive_write: assert property (acc_wr && paddr == TPG_OFF_CTRL |=> pulse_output_pin_oe == $past(pwdata[7]))
    else $error("drive enable does not follow write");
  a_mode_select: assert property (ctrl_r.enable && ctrl_r.mode |=> state_r == TPG_ST_TIMER)
    else $error("timer mode not entered");
  a_timer_start: assert property ($rose(state_r == TPG_ST_TIMER) |-> pre_r == '0 && cnt_r == 8'h00)
    else $error("timer did not start from zero");
  a_timer_wrap: assert property (s_wrap_hit |=> s_wrap_done ##0 tff_r != $past(tff_r))
    else $error("timer wrap did not clear, toggle and flag");
  // The run state lags the enable bit by one cycle, so the prescaler is
  // only certain to be cleared one cycle after two disabled cycles
  a_stop_clear: assert property (!ctrl_r.enable [*2] |=> pre_r == '0 && cnt_r == 8'h00)
    else $error("stopped generator still counting");
  a_flag_setwins: assert property (pwm_evt && stat_clr |=> irq_r)
    else $error("event lost against clear");
  a_ctrl_written: assert property (!acc_wr |=> ctrl_r == $past(ctrl_r))
    else $error("control changed without write");

endmodule : tpg_top

`default_nettype wire

// ===== testbench/tpg_load.sv
/*
  Far-side load on the pulse pin: resolves the pin wire and integrates
  the low time, as a low-pass filter would. Assumes the pin level and
  drive enable of the generator, both on pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module tpg_load
(
  // Clock
  input  wire logic pclk,
  // Pin from the generator
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Resolved wire and low-time integral
  output logic      pin_w,
  output var int    low_cnt
);
  logic last_r = 1'b0;

  // No pull on this pin: a floating wire must never look like a held level
  assign pin_w = pin_oe ? pin_o : ~last_r;

  initial low_cnt = 0;

  always @(posedge pclk)
  begin
    last_r <= pin_w;
    if (pin_w === 1'b0)
      low_cnt <= low_cnt + 1;
  end
endmodule : tpg_load

`default_nettype wire

// ===== testbench/timer_pulse_generator_tb.sv
/*
  Self-checking bench for the timer/pulse generator: APB register access,
  static pin, timer intervals for each one-hot prescaler code, PWM duty.
  Assumes tpg_top with zero-wait APB and the tpg_load pin model.
*/
`timescale 1ns/10ps
`default_nettype none

module timer_pulse_generator_tb
  import tpg_pkg::*;
;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_o;
  logic        pin_oe;
  logic        irq_flag;
  logic        irq_set;
  logic        pin_w;
  int          low_cnt;
  int          cyc        = 0;
  int          n_mismatch = 0;
  int          n_compared = 0;
  integer      seed       = 89694;
  logic [31:0] q;
  logic        e;

  tpg_top dut
  (
    .pclk                (pclk),
    .presetn             (presetn),
    .paddr               (paddr),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .pulse_output_pin_o  (pin_o),
    .pulse_output_pin_oe (pin_oe),
    .pulse_gen_irq_flag  (irq_flag),
    .pulse_gen_irq_set   (irq_set)
  );

  tpg_load load
  (
    .pclk    (pclk),
    .pin_o   (pin_o),
    .pin_oe  (pin_oe),
    .pin_w   (pin_w),
    .low_cnt (low_cnt)
  );

  always #4 pclk = ~pclk;

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Two PWM secondary periods dominate the run
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD timeout expected %0d seen %0d", 0, cyc);
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] s);
    n_compared++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask : rdc

  // The request pulse stands one cycle, so each call sees a fresh one
  task automatic wait_set(output int t);
    do
      @(posedge pclk);
    while (irq_set !== 1'b1);
    t = cyc;
  endtask : wait_set

  function automatic int tmr_ivl(input logic [4:0] code,
                                 input logic [7:0] n);
    int dv;
    dv = 0;
    for (int i = 0; i < 5; i++)
      if (code[i])
        dv = 256 >> i;
    return dv * (n + 1);
  endfunction : tmr_ivl

  function automatic int pwm_low(input logic [7:0] h, input logic [7:0] l);
    return 2 * {h, l[7:2]};
  endfunction : pwm_low

  initial
  begin : main
    int         t0;
    int         t1;
    int         tw;
    int         lo;
    logic [7:0] n;
    logic [7:0] h;
    logic [7:0] l;
    logic       p0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl_rst", TPG_OFF_CTRL, 32'h0);
    rdc("modulo_high_rst", TPG_OFF_MODULO_HIGH, 32'h0);
    rdc("modulo_low_rst", TPG_OFF_MODULO_LOW, 32'h0);
    rdc("stat_rst", TPG_OFF_STAT, 32'h0);
    chk("oe_rst", 32'h0, pin_oe);
    apb(1'b0, 12'h010, 32'h0);
    chk("rd_err", 32'h1, {q[31:1], e});
    apb(1'b1, 12'h014, 32'hff);
    chk("wr_err", 32'h1, e);
    // Prescaler field all ones is not one-hot, so the enabled timer never ticks
    apb(1'b1, TPG_OFF_MODULO_LOW, 32'hff);
    apb(1'b1, TPG_OFF_CTRL, 32'hff);
    rdc("ctrl_bits", TPG_OFF_CTRL, 32'hbb);
    apb(1'b0, TPG_OFF_MODULO_LOW, 32'h0);
    chk("modulo_low_rd", 32'hfc, q & 32'hfffffffc);
    h = 8'($random(seed));
    apb(1'b1, TPG_OFF_MODULO_HIGH, {24'h0, h});
    rdc("modulo_high_rd", TPG_OFF_MODULO_HIGH, {24'h0, h});
    for (int v = 0; v < 2; v++)
    begin
      apb(1'b1, TPG_OFF_CTRL, v ? 32'h90 : 32'h80);
      repeat (3) @(posedge pclk);
      chk("static", {30'h0, 1'b1, v[0]}, {pin_oe, pin_w});
    end
    apb(1'b1, TPG_OFF_CTRL, 32'h10);
    repeat (3) @(posedge pclk);
    chk("oe_off", 32'h0, pin_oe);
    for (int i = 0; i < 5; i++)
    begin
      n = 8'(1 + {$random(seed)} % 3);
      apb(1'b1, TPG_OFF_CTRL, 32'h0);
      apb(1'b1, TPG_OFF_MODULO_HIGH, {24'h0, n});
      apb(1'b1, TPG_OFF_MODULO_LOW, 32'h4 << i);
      apb(1'b1, TPG_OFF_CTRL, 32'hab);
      tw = cyc;
      wait_set(t0);
      chk("start", 32'h1, (t0 - tw) <= tmr_ivl(5'h1 << i, n) + 8);
      p0 = pin_w;
      wait_set(t1);
      chk("interval", tmr_ivl(5'h1 << i, n), t1 - t0);
      chk("square", {31'h0, ~p0}, pin_w);
      chk("flag", 32'h1, irq_flag);
      apb(1'b1, TPG_OFF_CTRL, 32'h0);
      apb(1'b1, TPG_OFF_STAT, 32'h1);
      rdc("flag_clr", TPG_OFF_STAT, 32'h0);
    end
    apb(1'b1, TPG_OFF_CTRL, 32'ha9);
    lo = 0;
    repeat (600)
    begin
      @(posedge pclk);
      lo = lo + (irq_set === 1'b1);
    end
    chk("stopped", 32'h0, lo);
    h = 8'(1 + {$random(seed)} % 255);
    l = 8'($random(seed)) & 8'hfc;
    apb(1'b1, TPG_OFF_MODULO_HIGH, {24'h0, h});
    apb(1'b1, TPG_OFF_MODULO_LOW, {24'h0, l});
    apb(1'b1, TPG_OFF_CTRL, 32'haa);
    // Reload off, then new values that must not reach the latch
    apb(1'b1, TPG_OFF_CTRL, 32'ha2);
    apb(1'b1, TPG_OFF_MODULO_HIGH, (h == 8'h01) ? 32'h2 : 32'h1);
    apb(1'b1, TPG_OFF_MODULO_LOW, {24'h0, ~l & 8'hfc});
    wait_set(t0);
    lo = low_cnt;
    wait_set(t1);
    chk("pwm_period", 32'd32768, t1 - t0);
    chk("pwm_low", pwm_low(h, l), low_cnt - lo);
    chk("pwm_flag", 32'h1, irq_flag);
    wrap_up();
  end
endmodule : timer_pulse_generator_tb

`default_nettype wire
